//--- rtl/ldcr_regs.sv
// Vendor configuration bank for the floppy, parallel and first serial logical devices,
// plus the small amount of pin steering those settings drive.
// Assumes index/data port decoding upstream: the current logical device number,
// the selected index and one-cycle read/write strobes arrive already decoded.
// What this block does
// R1 - Defaults only on power-on or bus reset
// R2 - Floppy mode bit0 selects enhanced mode
// R3 - Floppy mode bit1 selects non-burst DMA
// R4 - Bits 3:2 select floppy interface mode
// R5 - Swap bit exchanges drive 0/1 select, motor
// R6 - Output-type bit 0 gives open-drain drivers
// R7 - Output-control bit 0 keeps outputs driven
// R8 - Write-protect from forced, pin, or disable
// R9 - Density field forces density output 1/0
// R10 - Drive types for A, B; spare pairs kept
// R11 - Index F3 reads zero, ignores writes
// R12 - Drive 0 type, rate table, precomp disable
// R13 - Drive 1 register mirrors drive 0 layout
// R14 - Three-bit parallel port mode selection
// R15 - ECP FIFO threshold bits 6:3, default 0111
// R16 - Pulsed interrupt when type bit set, except in SPP and printer modes
// R17 - Interrupt follows ack in EPP-like modes
// R18 - Level interrupt in ECP/test/FIFO modes
// R19 - Timeout flag clear by write or read
// R20 - Serial mode bit0 enables MIDI
// R21 - Serial mode bit1 enables high speed
// R22 - Share bit makes both lines assert
// R23 - Shared line carries OR of requests
`include "ldcr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ldcr_regs
    import ldcr_pkg::*;
(
    input  wire logic       sys_clk_i, // 20 MHz clock
    input  wire logic       resetn_i, // Power-on or bus reset
    input  wire logic       soft_reset_i, // Ignored on purpose
    input  wire logic [7:0] ldn_i, // Logical device
    input  wire logic [7:0] cfg_index_i, // Index
    input  wire logic [7:0] cfg_wdata_i, // Write data
    input  wire logic       cfg_wr_i, // Write strobe
    input  wire logic       cfg_rd_i, // Read strobe
    output logic      [7:0] cfg_rdata_o, // Read data
    output logic            cfg_hit_o, // Index is ours
    // Floppy side
    input  wire logic [1:0] core_drive_select_n_i, // Core selects
    input  wire logic [1:0] core_motor_on_n_i, // Core motors
    input  wire logic       write_protect_in_n_i, // Protect pin
    input  wire logic       floppy_wp_disable_i, // Protect disable bit
    input  wire logic       core_density_i, // Core density
    output logic      [1:0] drive_select_n_o, // Select pins
    output logic      [1:0] motor_on_n_o, // Motor pins
    output logic            floppy_out_oe_o, // Outputs enabled
    output logic            floppy_push_pull_o, // 0 open drain
    output logic            write_protect_o, // To core, status_reg_a
    output logic            density_o, // Density pin
    output logic            floppy_enhanced_o, // Enhanced mode 2
    output logic            floppy_non_burst_o, // Non-burst DMA
    output logic      [1:0] floppy_ifmode_o, // Interface mode
    output logic      [7:0] drive_type_bits_o, // Drive types
    output logic      [1:0] drv0_type_o, // Drive 0 type
    output logic      [1:0] drv0_rate_o, // Drive 0 rate
    output logic            drv0_precomp_disable_o, // Drive 0 precomp off
    output logic      [1:0] drv1_type_o, // Drive 1 type
    output logic      [1:0] drv1_rate_o, // Drive 1 rate
    output logic            drv1_precomp_disable_o, // Drive 1 precomp off
    // Parallel side
    input  wire logic       ack_n_i, // Acknowledge pin
    input  wire logic       par_irq_req_i, // Port request
    input  wire logic       par_ecp_level_mode_i, // ECP, test or FIFO
    input  wire logic       epp_status_rd_i, // Status read
    input  wire logic       epp_timeout_set_i, // Timeout event
    input  wire logic       epp_timeout_wr1_i, // Flag written 1
    output logic      [2:0] par_mode_o, // Port mode
    output logic      [3:0] ecp_threshold_o, // FIFO threshold
    output logic            par_irq_o, // Irq value
    output logic            par_irq_oe_o, // Irq enable
    output logic            epp_timeout_flag_o, // Timeout flag
    // Serial side
    input  wire logic       uart1_irq_i, // Port 1 request
    input  wire logic       uart2_irq_i, // Port 2 request
    output logic            midi_en_o, // MIDI support
    output logic            high_speed_o, // High speed
    output logic            uart1_irq_o, // Line 1
    output logic            uart2_irq_o // Line 2
);

    logic [7:0] fmode_r, fmode_nxt;
    logic [7:0] fopt_r,  fopt_nxt;
    logic [7:0] ftype_r, ftype_nxt;
    logic [7:0] drv0_r,  drv0_nxt;
    logic [7:0] drv1_r,  drv1_nxt;
    logic [7:0] pmode_r, pmode_nxt;
    logic [7:0] pmod2_r, pmod2_nxt;
    logic [7:0] smode_r, smode_nxt;
    logic       tmo_r,   tmo_nxt;
    logic       srd_r,   srd_nxt;
    logic       ack_r,   ack_nxt;
    logic       pulse_r, pulse_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       hit;
    logic       wr_f, wr_p, wr_s;
    logic       is_f, is_p, is_s;
    ldcr_pmode_t pm;

    assign is_f = (ldn_i == `LDCR_LDN_FLOPPY);
    assign is_p = (ldn_i == `LDCR_LDN_PARALLEL);
    assign is_s = (ldn_i == `LDCR_LDN_SERIAL1);
    assign wr_f = cfg_wr_i && is_f;
    assign wr_p = cfg_wr_i && is_p;
    assign wr_s = cfg_wr_i && is_s;
    assign pm   = ldcr_pmode_t'(pmode_r[2:0]);

    // Register writes; reserved bits masked so they always read zero
    always_comb begin
        fmode_nxt = fmode_r;
        fopt_nxt  = fopt_r;
        ftype_nxt = ftype_r;
        drv0_nxt  = drv0_r;
        drv1_nxt  = drv1_r;
        pmode_nxt = pmode_r;
        pmod2_nxt = pmod2_r;
        smode_nxt = smode_r;
        if (wr_f && cfg_index_i == `LDCR_IDX_MODE) begin
            fmode_nxt = cfg_wdata_i & `LDCR_MSK_FLOPPY_MODE; // see R2, see R3, see R4
        end else if (wr_f && cfg_index_i == `LDCR_IDX_OPTION) begin
            fopt_nxt = cfg_wdata_i & `LDCR_MSK_FLOPPY_OPT;
        end else if (wr_f && cfg_index_i == `LDCR_IDX_TYPES) begin
            ftype_nxt = cfg_wdata_i; // see R10
        end else if (wr_f && cfg_index_i == `LDCR_IDX_DRV0) begin
            drv0_nxt = cfg_wdata_i & `LDCR_MSK_DRV; // see R12
        end else if (wr_f && cfg_index_i == `LDCR_IDX_DRV1) begin
            drv1_nxt = cfg_wdata_i & `LDCR_MSK_DRV; // see R13
        end else if (wr_p && cfg_index_i == `LDCR_IDX_MODE) begin
            pmode_nxt = cfg_wdata_i; // see R14, see R15
        end else if (wr_p && cfg_index_i == `LDCR_IDX_OPTION) begin
            pmod2_nxt = cfg_wdata_i & `LDCR_MSK_PAR_MODE2;
        end else if (wr_s && cfg_index_i == `LDCR_IDX_MODE) begin
            smode_nxt = cfg_wdata_i & `LDCR_MSK_SER1_MODE; // see R20, see R21
        end
        // Index F3 matches no branch, so writes there fall away; see R11
    end

    // Only resetn_i restores defaults; soft reset is not wired in on purpose
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin // see R1
            fmode_r <= `LDCR_RST_FLOPPY_MODE;
            fopt_r  <= `LDCR_RST_FLOPPY_OPT;
            ftype_r <= `LDCR_RST_TYPES;
            drv0_r  <= `LDCR_RST_DRV;
            drv1_r  <= `LDCR_RST_DRV;
            pmode_r <= `LDCR_RST_PAR_MODE;
            pmod2_r <= `LDCR_RST_PAR_MODE2;
            smode_r <= `LDCR_RST_SER1_MODE;
        end else begin
            fmode_r <= fmode_nxt;
            fopt_r  <= fopt_nxt;
            ftype_r <= ftype_nxt;
            drv0_r  <= drv0_nxt;
            drv1_r  <= drv1_nxt;
            pmode_r <= pmode_nxt;
            pmod2_r <= pmod2_nxt;
            smode_r <= smode_nxt;
        end
    end

    // Read mux, registered so read data stands one cycle after the strobe
    always_comb begin
        hit       = 1'b1;
        rdata_nxt = rdata_r;
        if (is_f && cfg_index_i == `LDCR_IDX_MODE) begin
            rdata_nxt = fmode_r;
        end else if (is_f && cfg_index_i == `LDCR_IDX_OPTION) begin
            rdata_nxt = fopt_r;
        end else if (is_f && cfg_index_i == `LDCR_IDX_TYPES) begin
            rdata_nxt = ftype_r;
        end else if (is_f && cfg_index_i == `LDCR_IDX_RSVD) begin
            rdata_nxt = 8'h00; // see R11
        end else if (is_f && cfg_index_i == `LDCR_IDX_DRV0) begin
            rdata_nxt = drv0_r;
        end else if (is_f && cfg_index_i == `LDCR_IDX_DRV1) begin
            rdata_nxt = drv1_r;
        end else if (is_p && cfg_index_i == `LDCR_IDX_MODE) begin
            rdata_nxt = pmode_r;
        end else if (is_p && cfg_index_i == `LDCR_IDX_OPTION) begin
            rdata_nxt = pmod2_r;
        end else if (is_s && cfg_index_i == `LDCR_IDX_MODE) begin
            rdata_nxt = smode_r;
        end else begin
            hit       = 1'b0;
            rdata_nxt = 8'h00;
        end
        if (!cfg_rd_i) begin
            rdata_nxt = rdata_r;
        end
    end

    // EPP timeout flag: a new event beats a clear in the same cycle
    always_comb begin
        srd_nxt = epp_status_rd_i;
        tmo_nxt = tmo_r;
        if (pmod2_r[`LDCR_PM2_TMO_BIT]) begin
            if (srd_r && !epp_status_rd_i) begin // see R19
                tmo_nxt = 1'b0;
            end
        end else if (epp_timeout_wr1_i) begin // see R19
            tmo_nxt = 1'b0;
        end
        if (epp_timeout_set_i) begin
            tmo_nxt = 1'b1;
        end
    end

    // Pulsed parallel interrupt: one low cycle per rising request, then released
    always_comb begin
        ack_nxt   = par_irq_req_i;
        pulse_nxt = par_irq_req_i && !ack_r;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
            tmo_r   <= 1'b0;
            srd_r   <= 1'b0;
            ack_r   <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            tmo_r   <= tmo_nxt;
            srd_r   <= srd_nxt;
            ack_r   <= ack_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign cfg_rdata_o        = rdata_r;
    assign cfg_hit_o          = hit;
    assign epp_timeout_flag_o = tmo_r;

    // Floppy mode and drive type fields
    assign floppy_enhanced_o  = fmode_r[`LDCR_FM_MODE_BIT]; // see R2
    assign floppy_non_burst_o = fmode_r[`LDCR_FM_DMA_BIT]; // see R3
    assign floppy_ifmode_o    = fmode_r[`LDCR_FM_IFM_LSB +: 2]; // see R4
    assign floppy_push_pull_o = fmode_r[`LDCR_FM_OTYPE_BIT]; // see R6
    assign floppy_out_oe_o    = !fmode_r[`LDCR_FM_OCTL_BIT]; // see R7
    assign drive_type_bits_o  = ftype_r; // see R10

    // Drive swap is purely combinational so select and motor move together
    always_comb begin
        if (fmode_r[`LDCR_FM_SWAP_BIT]) begin // see R5
            drive_select_n_o = {core_drive_select_n_i[0], core_drive_select_n_i[1]};
            motor_on_n_o     = {core_motor_on_n_i[0], core_motor_on_n_i[1]};
        end else begin
            drive_select_n_o = core_drive_select_n_i;
            motor_on_n_o     = core_motor_on_n_i;
        end
    end

    // Forced protect applies whenever a drive is selected (selects are active low)
    assign write_protect_o = (fopt_r[`LDCR_FO_FWP_BIT] && !(&core_drive_select_n_i))
                           || !write_protect_in_n_i || floppy_wp_disable_i;   // see R8

    always_comb begin
        case (fopt_r[`LDCR_FO_DENS_LSB +: 2]) // see R9
            2'b10:   density_o = 1'b1;
            2'b11:   density_o = 1'b0;
            default: density_o = core_density_i;
        endcase
    end

    // Per-drive settings
    assign drv0_type_o            = drv0_r[1:0]; // see R12
    assign drv0_rate_o            = drv0_r[4:3];
    assign drv0_precomp_disable_o = drv0_r[`LDCR_DRV_PRECOMP_BIT];
    assign drv1_type_o            = drv1_r[1:0]; // see R13
    assign drv1_rate_o            = drv1_r[4:3];
    assign drv1_precomp_disable_o = drv1_r[`LDCR_DRV_PRECOMP_BIT];

    // Parallel mode and interrupt styling
    assign par_mode_o      = pmode_r[2:0]; // see R14
    assign ecp_threshold_o = pmode_r[`LDCR_PM_THR_LSB +: 4]; // see R15

    always_comb begin
        par_irq_o    = par_irq_req_i;
        par_irq_oe_o = 1'b1;
        if (pmode_r[`LDCR_PM_ITYPE_BIT] && pm != LDCR_PM_PRINTER && pm != LDCR_PM_SPP) begin
            par_irq_o    = 1'b0; // see R16
            par_irq_oe_o = pulse_r;
        end else if (!pmode_r[`LDCR_PM_ITYPE_BIT] && par_ecp_level_mode_i) begin
            par_irq_o    = par_irq_req_i; // see R18
        end else if (!pmode_r[`LDCR_PM_ITYPE_BIT] && pm != LDCR_PM_PRINTER && pm != LDCR_PM_SPP) begin
            par_irq_o    = !ack_n_i; // see R17
        end
    end

    // Serial mode and interrupt sharing
    assign midi_en_o    = smode_r[`LDCR_SM_MIDI_BIT]; // see R20
    assign high_speed_o = smode_r[`LDCR_SM_HS_BIT]; // see R21
    assign uart1_irq_o  = smode_r[`LDCR_SM_SHARE_BIT] ? (uart1_irq_i || uart2_irq_i) : uart1_irq_i; // see R22, see R23
    assign uart2_irq_o  = smode_r[`LDCR_SM_SHARE_BIT] ? (uart1_irq_i || uart2_irq_i) : uart2_irq_i; // see R22, see R23

endmodule : ldcr_regs

`default_nettype wire

//--- rtl/ldcr_defs.svh
// Index, field position and reset-value macros for the logical device configuration bank.
// Assumes the includer sees a plain 8-bit config index and data path.
`ifndef LDCR_DEFS_SVH
`define LDCR_DEFS_SVH

`define LDCR_LDN_FLOPPY        8'h00
`define LDCR_LDN_PARALLEL      8'h03
`define LDCR_LDN_SERIAL1       8'h04

`define LDCR_IDX_MODE          8'hF0
`define LDCR_IDX_OPTION        8'hF1
`define LDCR_IDX_TYPES         8'hF2
`define LDCR_IDX_RSVD          8'hF3
`define LDCR_IDX_DRV0          8'hF4
`define LDCR_IDX_DRV1          8'hF5

`define LDCR_RST_FLOPPY_MODE   8'h0E
`define LDCR_RST_FLOPPY_OPT    8'h00
`define LDCR_RST_TYPES         8'hFF
`define LDCR_RST_DRV           8'h00
`define LDCR_RST_PAR_MODE      8'h3C
`define LDCR_RST_PAR_MODE2     8'h00
`define LDCR_RST_SER1_MODE     8'h00

// Writable-bit masks; zero bits are reserved and read back as zero
`define LDCR_MSK_FLOPPY_MODE   8'hDF
`define LDCR_MSK_FLOPPY_OPT    8'h0D
`define LDCR_MSK_DRV           8'h5B
`define LDCR_MSK_PAR_MODE2     8'h10
`define LDCR_MSK_SER1_MODE     8'h83

`define LDCR_FM_MODE_BIT       0
`define LDCR_FM_DMA_BIT        1
`define LDCR_FM_IFM_LSB        2
`define LDCR_FM_SWAP_BIT       4
`define LDCR_FM_OTYPE_BIT      6
`define LDCR_FM_OCTL_BIT       7
`define LDCR_FO_FWP_BIT        0
`define LDCR_FO_DENS_LSB       2
`define LDCR_DRV_PRECOMP_BIT   6
`define LDCR_PM_THR_LSB        3
`define LDCR_PM_ITYPE_BIT      7
`define LDCR_PM2_TMO_BIT       4
`define LDCR_SM_MIDI_BIT       0
`define LDCR_SM_HS_BIT         1
`define LDCR_SM_SHARE_BIT      7

`endif

//--- rtl/ldcr_pkg.sv
// Types for the logical device configuration bank.
// Assumes ldcr_defs.svh supplies the numeric constants.
`default_nettype none
package ldcr_pkg;

    typedef enum logic [1:0] {
        LDCR_IFM_MODEL30  = 2'b00,
        LDCR_IFM_ALT      = 2'b01,
        LDCR_IFM_RSVD     = 2'b10,
        LDCR_IFM_DEFAULT  = 2'b11
    } ldcr_ifm_t;

    typedef enum logic [2:0] {
        LDCR_PM_SPP       = 3'b000,
        LDCR_PM_EPP19     = 3'b001,
        LDCR_PM_ECP       = 3'b010,
        LDCR_PM_ECP_EPP19 = 3'b011,
        LDCR_PM_PRINTER   = 3'b100,
        LDCR_PM_EPP17     = 3'b101,
        LDCR_PM_RSVD      = 3'b110,
        LDCR_PM_ECP_EPP17 = 3'b111
    } ldcr_pmode_t;

endpackage : ldcr_pkg
`default_nettype wire

//--- tb/ldcr_regs_monitor.sv
// Concurrent checks on the vendor configuration bank, bound onto its ports.
// Assumes one clock domain and the active-low asynchronous reset of the bank.
`timescale 1ns/100ps
`default_nettype none
module ldcr_regs_monitor (
    input wire logic       sys_clk_i, // Clock
    input wire logic       resetn_i, // Reset, active low
    input wire logic       soft_reset_i, // Soft reset
    input wire logic [7:0] ldn_i, // Logical device
    input wire logic [7:0] cfg_index_i, // Index
    input wire logic [7:0] cfg_wdata_i, // Write data
    input wire logic       cfg_wr_i, // Write strobe
    input wire logic       cfg_rd_i, // Read strobe
    input wire logic [7:0] cfg_rdata_o, // Read data
    input wire logic [1:0] core_drive_select_n_i, // Core selects
    input wire logic [1:0] drive_select_n_o, // Select pins
    input wire logic       write_protect_in_n_i, // Protect pin
    input wire logic       floppy_wp_disable_i, // Protect disable
    input wire logic       write_protect_o, // Protect to core
    input wire logic       core_density_i, // Core density
    input wire logic       density_o, // Density pin
    input wire logic [2:0] par_mode_o, // Port mode
    input wire logic [3:0] ecp_threshold_o, // FIFO threshold
    input wire logic       par_irq_req_i, // Port request
    input wire logic       par_ecp_level_mode_i, // Level phase
    input wire logic       par_irq_o, // Irq value
    input wire logic       par_irq_oe_o, // Irq enable
    input wire logic       epp_status_rd_i, // Status read
    input wire logic       epp_timeout_set_i, // Timeout event
    input wire logic       epp_timeout_flag_o, // Timeout flag
    input wire logic       uart1_irq_i, // Port 1 request
    input wire logic       uart2_irq_i, // Port 2 request
    input wire logic       uart1_irq_o, // Line 1
    input wire logic       uart2_irq_o // Line 2
);
    logic [7:0] fm_r, fo_r, pm_r, p2_r, sm_r;
    logic [7:0] fm_nxt, fo_nxt, pm_nxt, p2_nxt, sm_nxt;
    logic       wr_fl, wr_pp, wr_sp;

    // Write decode per logical device
    assign wr_fl = cfg_wr_i && ldn_i == 8'h00;
    assign wr_pp = cfg_wr_i && ldn_i == 8'h03;
    assign wr_sp = cfg_wr_i && ldn_i == 8'h04;

    // Shadow of written settings; soft reset not wired in
    always_comb begin
        fm_nxt = (wr_fl && cfg_index_i == 8'hF0) ? cfg_wdata_i : fm_r;
        fo_nxt = (wr_fl && cfg_index_i == 8'hF1) ? cfg_wdata_i : fo_r;
        pm_nxt = (wr_pp && cfg_index_i == 8'hF0) ? cfg_wdata_i : pm_r;
        p2_nxt = (wr_pp && cfg_index_i == 8'hF1) ? cfg_wdata_i : p2_r;
        sm_nxt = (wr_sp && cfg_index_i == 8'hF0) ? cfg_wdata_i : sm_r;
    end

    // Shadow registers with the bank's defaults
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fm_r <= 8'h0E;
            fo_r <= 8'h00;
            pm_r <= 8'h3C;
            p2_r <= 8'h00;
            sm_r <= 8'h00;
        end else begin
            fm_r <= fm_nxt;
            fo_r <= fo_nxt;
            pm_r <= pm_nxt;
            p2_r <= p2_nxt;
            sm_r <= sm_nxt;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // Pulse mode: request edge opens one enabled low cycle, then the line floats
    sequence s_pulse_start;
        pm_r[7] && par_mode_o != 3'b100 && par_mode_o != 3'b000 && $rose(par_irq_req_i);
    endsequence
    sequence s_pulse_body;
        par_irq_oe_o && !par_irq_o ##1 !par_irq_oe_o;
    endsequence

    a_drive_swap: assert property (drive_select_n_o == (fm_r[4] ?
        {core_drive_select_n_i[0], core_drive_select_n_i[1]} : core_drive_select_n_i))
        else $error("drive select swap wrong");
    a_protect_merge: assert property (write_protect_o == (!write_protect_in_n_i ||
        floppy_wp_disable_i || (fo_r[0] && core_drive_select_n_i != 2'b11)))
        else $error("write protect wrong");
    a_density_force: assert property (density_o == (fo_r[3] ? !fo_r[2] : core_density_i))
        else $error("density output wrong");
    a_reserved_read: assert property (cfg_rd_i && ldn_i == 8'h00 && cfg_index_i == 8'hF3 |=>
        cfg_rdata_o == 8'h00) else $error("reserved index not zero");
    a_soft_hold: assert property (soft_reset_i && !cfg_wr_i |=>
        $stable(par_mode_o) && $stable(ecp_threshold_o)) else $error("soft reset changed settings");
    a_reset_default: assert property ($rose(resetn_i) |->
        par_mode_o == 3'b100 && ecp_threshold_o == 4'h7) else $error("port mode default wrong");
    a_irq_pulse: assert property (s_pulse_start |=> s_pulse_body)
        else $error("pulsed interrupt wrong");
    a_level_irq: assert property (!pm_r[7] && par_ecp_level_mode_i |->
        par_irq_oe_o && par_irq_o == par_irq_req_i) else $error("level interrupt wrong");
    a_timeout_clear: assert property (p2_r[4] && $fell(epp_status_rd_i) && !epp_timeout_set_i |->
        ##[0:2] !epp_timeout_flag_o) else $error("timeout flag not cleared by read");
    a_share_or: assert property (sm_r[7] |-> uart1_irq_o == (uart1_irq_i || uart2_irq_i) &&
        uart2_irq_o == uart1_irq_o) else $error("shared interrupt wrong");
endmodule : ldcr_regs_monitor

bind ldcr_regs ldcr_regs_monitor u_mon (.*);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the vendor configuration bank.
// Assumes decoded index/data accesses with one-cycle strobes and one 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       sys_clk_i, resetn_i, soft_reset_i, cfg_wr_i, cfg_rd_i, cfg_hit_o;
    logic [7:0] ldn_i, cfg_index_i, cfg_wdata_i, cfg_rdata_o, drive_type_bits_o;
    logic [1:0] core_drive_select_n_i, core_motor_on_n_i, drive_select_n_o, motor_on_n_o, floppy_ifmode_o;
    logic [1:0] drv0_type_o, drv0_rate_o, drv1_type_o, drv1_rate_o;
    logic       write_protect_in_n_i, floppy_wp_disable_i, core_density_i, floppy_out_oe_o, floppy_push_pull_o;
    logic       write_protect_o, density_o, floppy_enhanced_o, floppy_non_burst_o;
    logic       drv0_precomp_disable_o, drv1_precomp_disable_o, ack_n_i, par_irq_req_i, par_ecp_level_mode_i;
    logic       epp_status_rd_i, epp_timeout_set_i, epp_timeout_wr1_i, par_irq_o, par_irq_oe_o, epp_timeout_flag_o;
    logic [2:0] par_mode_o;
    logic [3:0] ecp_threshold_o;
    logic       uart1_irq_i, uart2_irq_i, midi_en_o, high_speed_o, uart1_irq_o, uart2_irq_o;
    int         errors, n_checks, cycles;
    localparam logic [7:0] LDN [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h04};
    localparam logic [7:0] IDX [9] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF0, 8'hF1, 8'hF0};
    localparam logic [7:0] DFL [9] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h00};
    localparam logic [7:0] MSK [9] = '{8'hDF, 8'h0D, 8'hFF, 8'h00, 8'h5B, 8'h5B, 8'hFF, 8'h10, 8'h83};

    ldcr_regs uut (.*);

    // Clock at 50 ns
    always #25 sys_clk_i = ~sys_clk_i;

    // Hang guard; the run needs under two hundred cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        if (errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    // Accesses start at an edge; strobe then low a cycle
    task automatic wr(input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
        ldn_i       <= l;
        cfg_index_i <= i;
        cfg_wdata_i <= d;
        cfg_wr_i    <= 1'b1;
        tick(1);
        cfg_wr_i <= 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] l, input logic [7:0] i, input logic [7:0] exp);
        ldn_i       <= l;
        cfg_index_i <= i;
        cfg_rd_i    <= 1'b1;
        tick(1);
        cfg_rd_i <= 1'b0;
        tick(1);
        chk(cfg_rdata_o, exp);
    endtask : rd

    task automatic pulse_reset();
        resetn_i <= 1'b0;
        tick(6);
        resetn_i <= 1'b1;
        tick(1);
        for (int k = 0; k < 9; k++) rd(LDN[k], IDX[k], DFL[k]);
        chk({1'b0, ecp_threshold_o, par_mode_o}, 8'h3C);
    endtask : pulse_reset

    // Main sequence
    initial begin
        {sys_clk_i, resetn_i, soft_reset_i, cfg_wr_i, cfg_rd_i, ldn_i, cfg_index_i, cfg_wdata_i} = '0;
        {core_drive_select_n_i, core_motor_on_n_i, write_protect_in_n_i, ack_n_i} = '1;
        {floppy_wp_disable_i, core_density_i, par_irq_req_i, par_ecp_level_mode_i} = '0;
        {epp_status_rd_i, epp_timeout_set_i, epp_timeout_wr1_i, uart1_irq_i, uart2_irq_i} = '0;
        {errors, n_checks, cycles} = '0;
        tick(1);
        pulse_reset();
        for (int k = 0; k < 9; k++) wr(LDN[k], IDX[k], 8'hFF);
        soft_reset_i <= 1'b1;
        tick(1);
        soft_reset_i <= 1'b0;
        tick(1);
        for (int k = 0; k < 9; k++) rd(LDN[k], IDX[k], MSK[k]);
        rd(8'h00, 8'hF6, 8'h00);
        chk({7'h0, cfg_hit_o}, 8'h00);
        chk({3'h0, drv0_precomp_disable_o, drv0_rate_o, drv0_type_o}, 8'h1F);
        chk({3'h0, drv1_precomp_disable_o, drv1_rate_o, drv1_type_o}, 8'h1F);
        chk({floppy_out_oe_o, floppy_push_pull_o, 2'b00, floppy_ifmode_o, floppy_non_burst_o, floppy_enhanced_o},
            8'h4F);
        chk({6'h0, high_speed_o, midi_en_o}, 8'h03);
        wr(8'h00, 8'hF2, 8'h1B);
        rd(8'h00, 8'hF2, 8'h1B);
        chk(drive_type_bits_o, 8'h1B);
        // Swap on, then off with the other mode bits cleared
        core_drive_select_n_i <= 2'b10;
        core_motor_on_n_i     <= 2'b01;
        tick(1);
        chk({4'h0, motor_on_n_o, drive_select_n_o}, 8'h09);
        chk({7'h0, write_protect_o}, 8'h01);
        wr(8'h00, 8'hF0, 8'h00);
        chk({4'h0, motor_on_n_o, drive_select_n_o}, 8'h06);
        chk({floppy_out_oe_o, floppy_push_pull_o, 2'b00, floppy_ifmode_o, floppy_non_burst_o, floppy_enhanced_o},
            8'h80);
        // Write protect off with no drive selected, then from pin and disable in turn
        core_drive_select_n_i <= 2'b11;
        tick(1);
        chk({7'h0, write_protect_o}, 8'h00);
        write_protect_in_n_i <= 1'b0;
        tick(1);
        chk({7'h0, write_protect_o}, 8'h01);
        write_protect_in_n_i <= 1'b1;
        floppy_wp_disable_i  <= 1'b1;
        tick(1);
        chk({7'h0, write_protect_o}, 8'h01);
        floppy_wp_disable_i <= 1'b0;
        // All four density codes against both core levels
        for (int d = 0; d < 4; d++) begin
            wr(8'h00, 8'hF1, 8'(d << 2));
            for (int c = 0; c < 2; c++) begin
                core_density_i <= c[0];
                tick(1);
                chk({7'h0, density_o}, (d == 2) ? 8'h01 : (d == 3) ? 8'h00 : 8'(c));
            end
        end
        // Every documented port mode with a distinct threshold
        for (int m = 0; m < 8; m++) begin
            if (m != 6) begin
                wr(8'h03, 8'hF0, {1'b0, 4'(15 - m), 3'(m)});
                chk({1'b0, ecp_threshold_o, par_mode_o}, {1'b0, 4'(15 - m), 3'(m)});
            end
        end
        par_ecp_level_mode_i <= 1'b1;
        par_irq_req_i        <= 1'b1;
        tick(1);
        chk({6'h0, par_irq_oe_o, par_irq_o}, 8'h03);
        par_irq_req_i <= 1'b0;
        tick(1);
        chk({6'h0, par_irq_oe_o, par_irq_o}, 8'h02);
        par_ecp_level_mode_i <= 1'b0;
        wr(8'h03, 8'hF0, 8'h01);
        ack_n_i <= 1'b0;
        tick(1);
        chk({6'h0, par_irq_oe_o, par_irq_o}, 8'h03);
        ack_n_i <= 1'b1;
        wr(8'h03, 8'hF0, 8'h82);
        par_irq_req_i <= 1'b1;
        tick(2);
        chk({6'h0, par_irq_oe_o, par_irq_o}, 8'h02);
        tick(1);
        chk({7'h0, par_irq_oe_o}, 8'h00);
        par_irq_req_i <= 1'b0;
        wr(8'h03, 8'hF0, 8'h84);
        par_irq_req_i <= 1'b1;
        tick(2);
        chk({6'h0, par_irq_oe_o, par_irq_o}, 8'h03);
        // Timeout flag: read clears with select set, then only a written one clears it
        for (int s = 1; s >= 0; s--) begin
            wr(8'h03, 8'hF1, 8'(s << 4));
            epp_timeout_set_i <= 1'b1;
            tick(1);
            epp_timeout_set_i <= 1'b0;
            epp_status_rd_i   <= 1'b1;
            tick(1);
            epp_status_rd_i <= 1'b0;
            tick(3);
            chk({7'h0, epp_timeout_flag_o}, 8'(1 - s));
        end
        epp_timeout_wr1_i <= 1'b1;
        tick(1);
        epp_timeout_wr1_i <= 1'b0;
        tick(2);
        chk({7'h0, epp_timeout_flag_o}, 8'h00);
        // Shared serial interrupt, then separate lines again
        wr(8'h04, 8'hF0, 8'h80);
        uart2_irq_i <= 1'b1;
        tick(1);
        chk({6'h0, uart2_irq_o, uart1_irq_o}, 8'h03);
        wr(8'h04, 8'hF0, 8'h00);
        chk({6'h0, uart2_irq_o, uart1_irq_o}, 8'h02);
        pulse_reset();
        results();
    end
endmodule : testbench
`default_nettype wire
